// ==== hdl/timer_pkg.sv ====
// constants, types and decode helpers shared by the prescaled down timer
// assumes one clock domain (pclk) and an apb slave with 32-bit data
package timer_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0]  PRESC_INDEX     = 8'hd2;
    localparam logic [7:0]  COUNT_INDEX     = 8'hd3;
    localparam logic [7:0]  STATUS_INDEX    = 8'hd4;
    localparam int          ADDR_WIDTH      = 12;
    localparam logic [11:0] PRESC_ADDR      = {2'h0, PRESC_INDEX, 2'h0};
    localparam logic [11:0] COUNT_ADDR      = {2'h0, COUNT_INDEX, 2'h0};
    localparam logic [11:0] STATUS_ADDR     = {2'h0, STATUS_INDEX, 2'h0};

    // status/control field positions
    localparam int          ZERO_BIT        = 7;
    localparam int          IRQ_EN_BIT      = 6;
    localparam int          DIR_BIT         = 5;
    localparam int          DATA_BIT        = 4;
    localparam int          RUN_BIT         = 3;
    localparam int          TAP_MSB         = 2;
    localparam int          TAP_LSB         = 0;

    // reset values
    localparam logic [6:0]  PRESC_INIT      = 7'h7f;
    localparam logic [7:0]  COUNT_INIT      = 8'hff;
    localparam logic [7:0]  COUNT_ZERO      = 8'h00;
    localparam logic [2:0]  TAP_INIT        = 3'h0;

    // internal counting clock is the core clock divided by this
    localparam int          INT_DIV         = 12;
    localparam logic [3:0]  INT_DIV_LAST    = 4'(INT_DIV - 1);

    // operating modes from direction and data bits
    typedef enum logic [1:0] {
        MODE_EVENT  = 2'b00,
        MODE_GATED  = 2'b01,
        MODE_OUTPUT = 2'b10
    } timer_mode_type;

    // mode decode, used by the counting path and the checks
    function automatic timer_mode_type mode_of(input logic dir, input logic data);
        timer_mode_type m;
        m = MODE_EVENT;
        if (dir)
            m = MODE_OUTPUT;
        else if (data)
            m = MODE_GATED;
        return m;
    endfunction : mode_of

    // true when the low tap bits of the prescaler are zero: period complete
    function automatic logic tap_hit(input logic [6:0] presc, input logic [2:0] tap);
        logic [7:0] mask;
        mask = (8'h01 << tap) - 8'h01;
        return (({1'b0, presc} & mask) == 8'h00);
    endfunction : tap_hit

endpackage : timer_pkg

// ==== hdl/timer_pin_sync.sv ====
// two-flop synchroniser for the timer pin, with level and rising-edge pulse
// assumes the pin is asynchronous to pclk
`timescale 1ns/100ps
`default_nettype none
module timer_pin_sync
    import timer_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic pin_raw,
    output logic      pin_level,
    output logic      pin_rise
);
    logic meta_reg;  // first stage, read only by sync_reg
    logic sync_reg;  // second stage
    logic last_reg;  // previous synchronised level

    // synchroniser chain and edge history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
        end else begin
            meta_reg <= pin_raw;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    assign pin_level = sync_reg;
    assign pin_rise  = sync_reg & ~last_reg;
endmodule : timer_pin_sync
`default_nettype wire

// ==== hdl/timer_int_clock.sv ====
// divide-by-twelve tick generator that forms the internal counting clock
// assumes pclk is the core clock
`timescale 1ns/100ps
`default_nettype none
module timer_int_clock
    import timer_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    output logic      int_tick
);
    logic [3:0] div_reg;  // free-running divider

    // counts 0..INT_DIV-1 and wraps; a tick once per wrap
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            div_reg <= 4'h0;
        else if (div_reg == INT_DIV_LAST)
            div_reg <= 4'h0;
        else
            div_reg <= div_reg + 4'h1;
    end

    assign int_tick = (div_reg == INT_DIV_LAST);
endmodule : timer_int_clock
`default_nettype wire

// ==== hdl/prescaled_down_timer.sv ====
// 8-bit down timer with 7-bit prescaler, apb register slave and timer pin
// assumes an apb master on pclk; pin is pin_in / pin_out / pin_oe
//
// Register access over APB is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module prescaled_down_timer
    import timer_pkg::*;
(
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ADDR_WIDTH-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  pin_in,
    output logic                       pin_out,
    output logic                       pin_oe,
    output logic                       timer_irq
);
    // register state
    logic [6:0]     presc_reg;      // prescaler count
    logic [7:0]     count_reg;      // timer count
    logic           zero_flag_reg;  // sticky underflow flag
    logic           irq_en_reg;     // interrupt enable
    logic           dir_reg;        // pin direction select
    logic           data_reg;       // pin data / input sub-mode
    logic           run_reg;        // prescaler run
    logic [2:0]     tap_reg;        // prescaler tap select
    // bus answer registers
    logic           pready_reg;
    logic [31:0]    prdata_reg;
    logic           pslverr_reg;
    // pin and interrupt output registers
    logic           pin_out_reg;
    logic           pin_oe_reg;
    logic           irq_reg;
    // combinational helpers
    logic           pin_level;      // synchronised pin
    logic           pin_rise;       // synchronised rising edge
    logic           int_tick;       // core clock / 12
    logic           access;         // access phase, answer not yet given
    logic           commit;         // edge where the master samples pready
    logic           hit_presc;
    logic           hit_count;
    logic           hit_status;
    logic           wr_presc;
    logic           wr_count;
    logic           wr_status;
    timer_mode_type mode;
    logic           src_tick;       // prescaler input clock event
    logic           step;           // prescaler decrements
    logic           count_tick;     // prescaler period complete
    logic           underflow;      // counter wraps 00h to ffh
    logic           zero_rise;      // flag low-to-high

    timer_pin_sync u_pin_sync (
        .pclk      (pclk),
        .presetn   (presetn),
        .pin_raw   (pin_in),
        .pin_level (pin_level),
        .pin_rise  (pin_rise)
    );

    timer_int_clock u_int_clock (
        .pclk     (pclk),
        .presetn  (presetn),
        .int_tick (int_tick)
    );

    // address decode and write strobes; writes land at the sampled-ready edge
    assign access     = psel & penable & ~pready_reg;
    assign commit     = psel & penable & pready_reg;
    assign hit_presc  = (paddr == PRESC_ADDR);
    assign hit_count  = (paddr == COUNT_ADDR);
    assign hit_status = (paddr == STATUS_ADDR);
    assign wr_presc   = commit & pwrite & hit_presc;
    assign wr_count   = commit & pwrite & hit_count;
    assign wr_status  = commit & pwrite & hit_status;

    // mode from direction and data bits
    assign mode = mode_of(dir_reg, data_reg);

    // select the prescaler input clock by mode
    always_comb begin
        case (mode)
            MODE_EVENT:  src_tick = pin_rise;
            MODE_GATED:  src_tick = int_tick & pin_level;
            MODE_OUTPUT: src_tick = int_tick;
            default:     src_tick = 1'b0;
        endcase
    end

    assign step       = run_reg & src_tick;
    assign count_tick = step & tap_hit(presc_reg, tap_reg);
    // a software write to the counter suppresses this wrap
    assign underflow  = count_tick & (count_reg == COUNT_ZERO) & ~wr_count;
    assign zero_rise  = underflow & ~zero_flag_reg;

    // one wait state: ready rises in the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            pready_reg <= 1'b0;
        else
            pready_reg <= access;
    end

    // read data and error captured with ready; unmapped reads zero and error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else if (access) begin
            pslverr_reg <= ~(hit_presc | hit_count | hit_status);
            if (pwrite)
                prdata_reg <= 32'h0000_0000;
            else if (hit_presc)
                prdata_reg <= {25'h000_0000, presc_reg};
            else if (hit_count)
                prdata_reg <= {24'h00_0000, count_reg};
            else if (hit_status)
                prdata_reg <= {24'h00_0000, zero_flag_reg, irq_en_reg, dir_reg,
                               data_reg, run_reg, tap_reg};
            else
                prdata_reg <= 32'h0000_0000;
        end else begin
            pslverr_reg <= 1'b0;
        end
    end

    // prescaler: held at 7fh while stopped, writable while running
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            presc_reg <= PRESC_INIT;
        else if (!run_reg)
            presc_reg <= PRESC_INIT;
        else if (wr_presc)
            presc_reg <= pwdata[6:0];
        else if (step)
            presc_reg <= presc_reg - 7'h01;
    end

    // counter: write wins over the decrement in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            count_reg <= COUNT_INIT;
        else if (wr_count)
            count_reg <= pwdata[7:0];
        else if (count_tick)
            count_reg <= count_reg - 8'h01;
    end

    // zero flag: hardware sets, only software clears; set beats clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            zero_flag_reg <= 1'b0;
        else if (underflow)
            zero_flag_reg <= 1'b1;
        else if (wr_status)
            zero_flag_reg <= pwdata[ZERO_BIT];
    end

    // control fields of the status/control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_en_reg <= 1'b0;
            dir_reg    <= 1'b0;
            data_reg   <= 1'b0;
            run_reg    <= 1'b0;
            tap_reg    <= TAP_INIT;
        end else if (wr_status) begin
            irq_en_reg <= pwdata[IRQ_EN_BIT];
            dir_reg    <= pwdata[DIR_BIT];
            data_reg   <= pwdata[DATA_BIT];
            run_reg    <= pwdata[RUN_BIT];
            tap_reg    <= pwdata[TAP_MSB:TAP_LSB];
        end
    end

    // pin latch: data bit captured only on the flag's rising edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            pin_out_reg <= 1'b0;
        else if (zero_rise)
            pin_out_reg <= data_reg;
    end

    // driver enable follows direction; input mode never drives the pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            pin_oe_reg <= 1'b0;
        else
            pin_oe_reg <= dir_reg;
    end

    // interrupt request level, one cycle behind flag and enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            irq_reg <= 1'b0;
        else
            irq_reg <= zero_flag_reg & irq_en_reg;
    end

    assign prdata    = prdata_reg;
    assign pready    = pready_reg;
    assign pslverr   = pslverr_reg;
    assign pin_out   = pin_out_reg;
    assign pin_oe    = pin_oe_reg;
    assign timer_irq = irq_reg;

    // checks on the design's own outputs
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // an underflow wraps the counter to ffh and sets the flag at the next edge
    underflow_sets_flag_a: assert property (
        underflow |=> zero_flag_reg && count_reg == COUNT_INIT)
        else $error("underflow did not set flag and wrap counter");

    // the flag only rises on a true underflow or a software write of one
    flag_source_a: assert property (
        $rose(zero_flag_reg) |-> $past(underflow) || $past(wr_status))
        else $error("zero flag rose without underflow or write");

    // only software may take the flag down again
    flag_sticky_a: assert property (
        zero_flag_reg && !wr_status |=> zero_flag_reg)
        else $error("zero flag cleared without a software write");

    // request level is the registered and of flag and enable
    irq_gating_a: assert property (
        ##1 timer_irq == ($past(zero_flag_reg) && $past(irq_en_reg)))
        else $error("irq does not match flag and enable");

    // driver follows the direction bit one cycle late, in both directions
    pin_drive_dir_a: assert property (
        ##1 pin_oe == $past(dir_reg))
        else $error("pin driver does not follow direction bit");

    // the latch takes the data bit at a flag rise
    pin_latch_a: assert property (
        zero_rise |=> pin_out == $past(data_reg))
        else $error("pin did not take data bit at flag rise");

    // and at no other time, so a software flag write never moves the pin
    pin_hold_a: assert property (
        !zero_rise |=> $stable(pin_out))
        else $error("pin changed without a flag rise");

    // stopped: prescaler pinned to its start value
    stopped_hold_a: assert property (
        !run_reg |=> presc_reg == PRESC_INIT)
        else $error("prescaler not held while stopped");

    // stopped: counter moves only by software
    counter_frozen_a: assert property (
        !run_reg && !wr_count |=> $stable(count_reg))
        else $error("counter moved while stopped");

    // running: each input event takes one off the prescaler
    presc_step_a: assert property (
        step && !wr_presc |=> presc_reg == $past(presc_reg) - 7'h01)
        else $error("prescaler did not step down");

    // a completed prescaler period takes one off the counter
    count_step_a: assert property (
        count_tick && !wr_count |=> count_reg == $past(count_reg) - 8'h01)
        else $error("counter did not step once per period");

    // event mode: without a synchronised rising edge the prescaler stands
    event_edge_a: assert property (
        mode == MODE_EVENT && !pin_rise && !wr_presc && run_reg |=> $stable(presc_reg))
        else $error("event prescaler moved without a pin edge");

    // gated mode: a low pin stops the internal ticks reaching the prescaler
    gate_low_a: assert property (
        mode == MODE_GATED && !pin_level && !wr_presc && run_reg
        |=> $stable(presc_reg))
        else $error("gated prescaler moved with pin low");

    // a counter write in a stepping cycle wins and leaves the flag alone
    write_wins_a: assert property (
        wr_count && count_tick |=> count_reg == $past(pwdata[7:0])
            && zero_flag_reg == $past(zero_flag_reg))
        else $error("counter write lost to decrement");

    // the error answer only ever stands beside ready
    slverr_ready_a: assert property (
        pslverr |-> pready)
        else $error("error answer without ready");

    // exactly one wait state, and ready never stretches
    ready_spacing_a: assert property (
        access |=> pready ##1 !pready)
        else $error("ready not a single-cycle answer");

    // main scenarios: underflow with request, write collision, each mode
    cover_underflow_c: cover property (underflow ##2 timer_irq [*2]);
    cover_collide_c:   cover property (wr_count && count_tick);
    cover_gated_c:     cover property (mode == MODE_GATED && count_tick);
    cover_event_c:     cover property (mode == MODE_EVENT && pin_rise && step);
    cover_output_c:    cover property (zero_rise && dir_reg);
endmodule : prescaled_down_timer
`default_nettype wire

// ==== tb/timer_pin_model.sv ====
// far side of the timer pin: a signal source in input modes, a load in output mode
// assumes pclk from the bench; src_mode is set by the bench between tests
`timescale 1ns/100ps
`default_nettype none
module timer_pin_model (
    input  wire logic       pclk,
    input  wire logic [1:0] src_mode,  // 0 low, 1 high, 2 pulse train
    input  wire logic       pin_out,
    input  wire logic       pin_oe,
    output logic            pin_wire
);
    logic [2:0] phase_reg = 3'h0;  // pulse train phase
    logic       src_level;         // what the source would put on the pin

    // each level lasts four cycles, so the synchroniser never misses one
    always @(posedge pclk) begin
        phase_reg <= phase_reg + 3'h1;
    end

    // pulse train gives one rising edge every eight cycles
    assign src_level = (src_mode == 2'h2) ? phase_reg[2] : src_mode[0];
    // push-pull driver of the device wins the wire while enabled
    assign pin_wire  = pin_oe ? pin_out : src_level;
endmodule : timer_pin_model
`default_nettype wire

// ==== tb/prescaled_down_timer_tb_top.sv ====
// self-checking bench for the prescaled down timer: apb master and pin model
// assumes timer_pkg and the design files are compiled before it
`timescale 1ns/100ps
`default_nettype none
module prescaled_down_timer_tb_top;
    import timer_pkg::*;
    logic        pclk    = 1'b0;  // 125 mhz core clock
    logic        presetn = 1'b0;  // reset held for two cycles
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rd;              // read data taken at the completing edge
    logic        pready, pslverr, pin_in, pin_out, pin_oe, timer_irq, err;
    logic [1:0]  src_mode = 2'h0; // far side source kind
    logic [7:0]  v;
    logic        d, en;
    int          n;
    int          num_errors = 0;
    int          checked = 0;

    always #4 pclk = ~pclk;

    prescaled_down_timer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .timer_irq(timer_irq));
    timer_pin_model i_pin (.pclk(pclk), .src_mode(src_mode), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_wire(pin_in));

    // interrupt request expected from a status value
    function automatic logic exp_irq(input logic [7:0] s);
        return s[ZERO_BIT] & s[IRQ_EN_BIT];
    endfunction : exp_irq

    // core cycles for one counter step at a tap
    function automatic int step_cycles(input int tap);
        return INT_DIV << tap;
    endfunction : step_cycles

    // exact comparison, unknowns count as mismatches
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    // window comparison for counts whose phase to the tick is unknown
    task automatic check_rng(input string name, input logic [7:0] lo, hi, got);
        checked++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            num_errors++;
            $display("wrong value %s expected %h..%h seen %h", name, lo, hi, got);
        end
    endtask : check_rng

    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] dat);
        int k;
        k = 0;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= dat;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd  = prdata;
        err = pslverr;
        check("pready", 32'h1, {31'h0, pready});
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // verdict, reached from the main sequence or the watchdog
    task automatic results();
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results

    // watchdog, well beyond the expected run length
    initial begin
        repeat (80000) @(posedge pclk);
        num_errors++;
        results();
    end

    initial begin
        void'($urandom(74));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        // reset values
        apb(1'b0, PRESC_ADDR, 32'h0);
        check("prescaler", 32'h7f, rd);
        apb(1'b0, COUNT_ADDR, 32'h0);
        check("counter", 32'hff, rd);
        apb(1'b0, STATUS_ADDR, 32'h0);
        check("status", 32'h0, rd);
        // unmapped place is refused
        apb(1'b1, 12'h000, 32'hff);
        check("slverr", 32'h1, {31'h0, err});
        // random control values with counting stopped
        for (int i = 0; i < 6; i++) begin
            v = 8'($urandom()) & 8'hf7;
            apb(1'b1, STATUS_ADDR, {24'h0, v});
            apb(1'b0, STATUS_ADDR, 32'h0);
            check("status", {24'h0, v}, rd);
            check("irq", {31'h0, exp_irq(v)}, {31'h0, timer_irq});
            check("pin_oe", {31'h0, v[DIR_BIT]}, {31'h0, pin_oe});
        end
        // stopped: counter frozen, prescaler pinned, its write ignored
        apb(1'b1, STATUS_ADDR, 32'h0);
        apb(1'b1, COUNT_ADDR, 32'h5a);
        apb(1'b1, PRESC_ADDR, 32'h10);
        repeat (200) @(posedge pclk);
        apb(1'b0, COUNT_ADDR, 32'h0);
        check("frozen counter", 32'h5a, rd);
        apb(1'b0, PRESC_ADDR, 32'h0);
        check("pinned prescaler", 32'h7f, rd);
        // every tap: eight counter steps in eight periods
        for (int t = 0; t < 8; t++) begin
            apb(1'b1, COUNT_ADDR, 32'hff);
            apb(1'b1, STATUS_ADDR, 32'h28 | t);
            repeat (8 * step_cycles(t)) @(posedge pclk);
            apb(1'b0, COUNT_ADDR, 32'h0);
            check_rng("step rate", 8'hf6, 8'hf8, rd[7:0]);
            apb(1'b1, STATUS_ADDR, 32'h20);
        end
        // underflows in output mode: data bit, enable on and off
        for (int i = 0; i < 3; i++) begin
            d  = (i != 1);
            en = (i != 2);
            apb(1'b1, COUNT_ADDR, 32'($urandom_range(9, 2)));
            apb(1'b1, STATUS_ADDR, {24'h0, 1'b0, en, 1'b1, d, 4'h8});
            n = 0;
            do begin
                apb(1'b0, STATUS_ADDR, 32'h0);
                n++;
            end while (rd[ZERO_BIT] !== 1'b1 && n < 100);
            check("zero flag", 32'h1, {31'h0, rd[ZERO_BIT]});
            repeat (2) @(posedge pclk);
            check("pin_out", {31'h0, d}, {31'h0, pin_out});
            check("pin_oe", 32'h1, {31'h0, pin_oe});
            check("irq", {31'h0, en}, {31'h0, timer_irq});
            repeat (40) @(posedge pclk);
            apb(1'b0, STATUS_ADDR, 32'h0);
            check("flag held", 32'h1, {31'h0, rd[ZERO_BIT]});
        end
        // counter writes at every phase of the tick: write wins, no underflow
        apb(1'b1, STATUS_ADDR, 32'h28);
        for (int i = 0; i < 12; i++) begin
            apb(1'b1, COUNT_ADDR, 32'h01);
            @(posedge pclk);
        end
        apb(1'b0, STATUS_ADDR, 32'h0);
        check("flag after writes", 32'h28, rd);
        apb(1'b0, COUNT_ADDR, 32'h0);
        check_rng("written counter", 8'h00, 8'h01, rd[7:0]);
        // gated counting: frozen while the pin is low, ticking while high
        // direction first, so the driven high level has left the synchroniser
        apb(1'b1, STATUS_ADDR, 32'h18);
        apb(1'b1, COUNT_ADDR, 32'hff);
        repeat (200) @(posedge pclk);
        apb(1'b0, COUNT_ADDR, 32'h0);
        check("gate low", 32'hff, rd);
        src_mode <= 2'h1;
        repeat (120) @(posedge pclk);
        apb(1'b0, COUNT_ADDR, 32'h0);
        check_rng("gate high", 8'hf4, 8'hf6, rd[7:0]);
        // event counting: one step per rising edge of the pin
        src_mode <= 2'h2;
        apb(1'b1, STATUS_ADDR, 32'h08);
        apb(1'b1, COUNT_ADDR, 32'hff);
        repeat (128) @(posedge pclk);
        apb(1'b0, COUNT_ADDR, 32'h0);
        check_rng("events", 8'hee, 8'hf0, rd[7:0]);
        check("pin_oe", 32'h0, {31'h0, pin_oe});
        results();
    end
endmodule : prescaled_down_timer_tb_top
`default_nettype wire
